// file: rtl/itc_pkg.sv
package itc_pkg;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int IDX_W    = 6;
   localparam int BYTE_LSB = 2;
   localparam int NUM_SRC  = 4;
   localparam int CNT_W    = 16;
   localparam int PIT_W    = 12;
   localparam int PIT_HI   = 8;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CAP_A_RISE = 6'h22;
   localparam logic [IDX_W-1:0] IDX_CAP_B_RISE = 6'h23;
   localparam logic [IDX_W-1:0] IDX_CAP_A_FALL = 6'h24;
   localparam logic [IDX_W-1:0] IDX_CAP_B_FALL = 6'h25;
   localparam logic [IDX_W-1:0] IDX_CNT_LO     = 6'h26;
   localparam logic [IDX_W-1:0] IDX_CNT_HI     = 6'h27;
   localparam logic [IDX_W-1:0] IDX_RLD_LO     = 6'h28;
   localparam logic [IDX_W-1:0] IDX_RLD_HI     = 6'h29;
   localparam logic [IDX_W-1:0] IDX_CFG        = 6'h2A;
   localparam logic [IDX_W-1:0] IDX_IEN        = 6'h2B;
   localparam logic [IDX_W-1:0] IDX_STS        = 6'h2C;

   // capture register index per source: A rise, A fall, B rise, B fall
   localparam logic [IDX_W-1:0] CAP_IDX [NUM_SRC] = '{6'h22, 6'h24, 6'h23, 6'h25};

   // configuration fields
   localparam int CFG_HOLD_BIT = 7;
   localparam int CFG_PRE_MSB  = 6;
   localparam int CFG_PRE_LSB  = 4;
   localparam int CFG_WIDE_BIT = 3;
   localparam logic [7:0] CFG_WMASK = 8'hF8;
   localparam logic [7:0] RST_BYTE  = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // sample clock rate derived from the system clock
   localparam int CLK_PERIOD_NS    = 10;
   localparam int SAMPLE_PERIOD_NS = 250;
   localparam int TICK_CYC         = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W           = 5;
endpackage : itc_pkg

// file: rtl/itc_top.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module itc_top (
   input  wire logic                        CLK,
   input  wire logic                        NRST,
   input  wire logic [itc_pkg::ADDR_W-1:0]  AWADDR,
   input  wire logic                        AWVALID,
   output logic                             AWREADY,
   input  wire logic [itc_pkg::DATA_W-1:0]  WDATA,
   input  wire logic [3:0]                  WSTRB,
   input  wire logic                        WVALID,
   output logic                             WREADY,
   output logic [1:0]                       BRESP,
   output logic                             BVALID,
   input  wire logic                        BREADY,
   input  wire logic [itc_pkg::ADDR_W-1:0]  ARADDR,
   input  wire logic                        ARVALID,
   output logic                             ARREADY,
   output logic [itc_pkg::DATA_W-1:0]       RDATA,
   output logic [1:0]                       RRESP,
   output logic                             RVALID,
   input  wire logic                        RREADY,
   input  wire logic                        CAPTURE_INPUT_A,
   input  wire logic                        CAPTURE_INPUT_B,
   output logic [itc_pkg::NUM_SRC-1:0]      CAPTURE_IRQ,
   output logic                             INTERVAL_IRQ
);
   import itc_pkg::*;

   logic [ADDR_W-1:0]  aw_addr_r;
   logic [7:0]         w_data_r;
   logic               w_strb_r;
   logic               aw_full_r, w_full_r;
   logic               awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0]         bresp_r, rresp_r;
   logic [DATA_W-1:0]  rdata_r;
   logic               aw_take, w_take, do_wr, ar_take;
   logic               aw_full_nxt, w_full_nxt;
   logic [IDX_W-1:0]   wr_idx, rd_idx;
   logic               wr_byte;
   logic [7:0]         rd_byte;
   logic               rd_ok;

   logic [TICK_W-1:0]  tick_cnt_r;
   logic               tick;
   logic [CNT_W-1:0]   free_cnt_r;
   logic [PIT_W-1:0]   count_r;
   logic [3:0]         count_hi_r;
   logic [7:0]         reload_lo_r;
   logic [3:0]         reload_hi_r;
   logic               pit_irq_r;
   logic [7:0]         cfg_r;
   logic [NUM_SRC-1:0] ien_r, sts_r, irq_r, held_r;
   logic [7:0]         cap_r [NUM_SRC];
   logic [1:0]         in_meta_r, in_sync_r, in_prev_r;
   logic [NUM_SRC-1:0] edge_ev, ev_ok, ld, rd_hit, clr_held;
   logic               hold, wide;
   logic [7:0]         sel8;

   assign AWREADY      = awready_r;
   assign WREADY       = wready_r;
   assign BVALID       = bvalid_r;
   assign BRESP        = bresp_r;
   assign ARREADY      = arready_r;
   assign RVALID       = rvalid_r;
   assign RRESP        = rresp_r;
   assign RDATA        = rdata_r;
   assign CAPTURE_IRQ  = irq_r;
   assign INTERVAL_IRQ = pit_irq_r;

   // write channel: address and data are taken in either order
   assign aw_take     = AWVALID & awready_r;
   assign w_take      = WVALID & wready_r;
   assign do_wr       = aw_full_r & w_full_r & ~bvalid_r;
   assign aw_full_nxt = (aw_full_r | aw_take) & ~do_wr;
   assign w_full_nxt  = (w_full_r | w_take) & ~do_wr;
   assign wr_idx      = aw_addr_r[BYTE_LSB +: IDX_W];
   assign wr_byte     = do_wr & w_strb_r;   // data lives in byte lane 0

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= RST_BYTE;
         w_strb_r  <= 1'b0;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready_r <= ~aw_full_nxt;
         wready_r  <= ~w_full_nxt;
         if (aw_take) begin
            aw_addr_r <= AWADDR;
         end
         if (w_take) begin
            w_data_r <= WDATA[7:0];
            w_strb_r <= WSTRB[0];
         end
      end
   end

   // write response: unmapped addresses answer with a slave error
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (wr_idx >= IDX_CAP_A_RISE && wr_idx <= IDX_STS) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // read channel: one read in flight, answered the cycle after acceptance
   assign ar_take = ARVALID & arready_r;
   assign rd_idx  = ARADDR[BYTE_LSB +: IDX_W];

   always_comb begin
      rd_ok   = 1'b1;
      rd_byte = RST_BYTE;
      case (rd_idx)
         IDX_CAP_A_RISE: rd_byte = cap_r[0];
         IDX_CAP_A_FALL: rd_byte = cap_r[1];
         IDX_CAP_B_RISE: rd_byte = cap_r[2];
         IDX_CAP_B_FALL: rd_byte = cap_r[3];
         IDX_CNT_LO:     rd_byte = count_r[7:0];
         IDX_CNT_HI:     rd_byte = {4'h0, count_hi_r};
         IDX_RLD_LO:     rd_byte = reload_lo_r;
         IDX_RLD_HI:     rd_byte = {4'h0, reload_hi_r};
         IDX_CFG:        rd_byte = cfg_r;
         IDX_IEN:        rd_byte = {4'h0, ien_r};
         IDX_STS:        rd_byte = {4'h0, sts_r};
         default:        rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
      end else begin
         arready_r <= ~ar_take & ~(rvalid_r & ~RREADY);
         if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h000000, rd_byte};
            rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (RREADY) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // software registers; reserved bits are never stored
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         reload_lo_r <= RST_BYTE;
         reload_hi_r <= 4'h0;
         cfg_r       <= RST_BYTE;
         ien_r       <= '0;
      end else if (wr_byte) begin
         case (wr_idx)
            IDX_RLD_LO: reload_lo_r <= w_data_r;
            IDX_RLD_HI: reload_hi_r <= w_data_r[3:0];
            IDX_CFG:    cfg_r       <= w_data_r & CFG_WMASK;
            IDX_IEN:    ien_r       <= w_data_r[NUM_SRC-1:0];
            default:    ;
         endcase
      end
   end

   // sample-clock enable from a divider, keeps one clock domain
   assign tick = (tick_cnt_r == TICK_W'(TICK_CYC - 1));

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      end
   end

   // free-running count advances only on the sample enable
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         free_cnt_r <= '0;
      end else if (tick) begin
         free_cnt_r <= free_cnt_r + 1'b1;
      end
   end

   // interval timer: down count, reload on expiry with a one-cycle pulse;
   // the reload pair is only sampled at expiry, so a low-then-high write
   // sequence is never seen half done unless expiry falls between them
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         count_r   <= '0;
         pit_irq_r <= 1'b0;
      end else begin
         pit_irq_r <= 1'b0;
         if (tick) begin
            if (count_r == '0) begin
               count_r   <= {reload_hi_r, reload_lo_r};
               pit_irq_r <= 1'b1;
            end else begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end

   // low-byte read freezes the upper nibble for a coherent pair
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         count_hi_r <= 4'h0;
      end else if (ar_take && rd_idx == IDX_CNT_LO) begin
         count_hi_r <= count_r[PIT_W-1:PIT_HI];
      end
   end

   // pins are asynchronous: two flops, then edge detect on the second
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         in_meta_r <= 2'b00;
         in_sync_r <= 2'b00;
         in_prev_r <= 2'b00;
      end else begin
         in_meta_r <= {CAPTURE_INPUT_B, CAPTURE_INPUT_A};
         in_sync_r <= in_meta_r;
         in_prev_r <= in_sync_r;
      end
   end

   assign edge_ev = {~in_sync_r[1] & in_prev_r[1], in_sync_r[1] & ~in_prev_r[1],
                     ~in_sync_r[0] & in_prev_r[0], in_sync_r[0] & ~in_prev_r[0]};
   assign hold    = cfg_r[CFG_HOLD_BIT];
   assign wide    = cfg_r[CFG_WIDE_BIT];
   assign sel8    = 8'(free_cnt_r >> cfg_r[CFG_PRE_MSB:CFG_PRE_LSB]);

   // per-source capture: unit A is sources 0-1, unit B is sources 2-3
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_cap
      if (i < 2) begin : g_a
         // held edge blocks later ones until the register is read
         assign ev_ok[i]    = edge_ev[i] & ~(hold & held_r[i]);
         assign ld[i]       = ev_ok[i];
         assign clr_held[i] = rd_hit[i] | (wide & rd_hit[i+2]);
         always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
               cap_r[i] <= RST_BYTE;
            end else if (ld[i]) begin
               cap_r[i] <= wide ? free_cnt_r[7:0] : sel8;
            end
         end
      end else begin : g_b
         // wide mode silences unit B and borrows its registers
         assign ev_ok[i]    = edge_ev[i] & ~(hold & held_r[i]) & ~wide;
         assign ld[i]       = wide ? ev_ok[i-2] : ev_ok[i];
         assign clr_held[i] = rd_hit[i];
         always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
               cap_r[i] <= RST_BYTE;
            end else if (ld[i]) begin
               cap_r[i] <= wide ? free_cnt_r[CNT_W-1:8] : sel8;
            end
         end
      end

      assign rd_hit[i] = ar_take & (rd_idx == CAP_IDX[i]);

      // a fresh capture wins over a read in the same cycle
      always_ff @(posedge CLK or negedge NRST) begin
         if (!NRST) begin
            held_r[i] <= 1'b0;
         end else if (ev_ok[i] && hold) begin
            held_r[i] <= 1'b1;
         end else if (clr_held[i]) begin
            held_r[i] <= 1'b0;
         end
      end

      // sticky status: set beats a write-one clear
      always_ff @(posedge CLK or negedge NRST) begin
         if (!NRST) begin
            sts_r[i] <= 1'b0;
         end else if (ev_ok[i]) begin
            sts_r[i] <= 1'b1;
         end else if (wr_byte && wr_idx == IDX_STS && w_data_r[i]) begin
            sts_r[i] <= 1'b0;
         end
      end
   end

   // level request per source stays up until software clears status
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         irq_r <= '0;
      end else begin
         irq_r <= sts_r & ien_r;
      end
   end

   a_irq_follows_sts: assert property (@(posedge CLK) disable iff (!NRST)
      (sts_r[0] & ien_r[0]) |=> CAPTURE_IRQ[0]) else $error("capture irq missing");
   a_sts_set_edge: assert property (@(posedge CLK) disable iff (!NRST)
      ev_ok[2] |=> sts_r[2] ##1 CAPTURE_IRQ[2] == $past(ien_r[2])) else $error("status not set");
   a_hold_keeps: assert property (@(posedge CLK) disable iff (!NRST)
      (hold & held_r[0] & ~clr_held[0]) |=> $stable(cap_r[0])) else $error("held capture changed");
   a_latest_edge: assert property (@(posedge CLK) disable iff (!NRST)
      (~hold & edge_ev[1] & ~wide) |=> cap_r[1] == $past(sel8)) else $error("capture not overwritten");
   a_wide_upper: assert property (@(posedge CLK) disable iff (!NRST)
      (wide & ev_ok[1]) |=> cap_r[3] == $past(free_cnt_r[CNT_W-1:8])) else $error("upper byte wrong");
   a_narrow_b_fall: assert property (@(posedge CLK) disable iff (!NRST)
      (~wide & ev_ok[3]) |=> cap_r[3] == $past(sel8)) else $error("unit b fall wrong");
   a_cnt_hi_latch: assert property (@(posedge CLK) disable iff (!NRST)
      (ar_take && rd_idx == IDX_CNT_LO) |=> count_hi_r == $past(count_r[PIT_W-1:PIT_HI]))
      else $error("nibble not latched");
   a_pit_reload: assert property (@(posedge CLK) disable iff (!NRST)
      (tick && count_r == '0) |=> INTERVAL_IRQ && count_r[PIT_HI-1:0] == $past(reload_lo_r)
                                  && count_r[PIT_W-1:PIT_HI] == $past(reload_hi_r))
      else $error("interval reload wrong");
   a_b_silent_wide: assert property (@(posedge CLK) disable iff (!NRST)
      wide |=> (sts_r[3:2] & ~$past(sts_r[3:2])) == 2'b00) else $error("unit b active in wide mode");
   a_free_on_tick: assert property (@(posedge CLK) disable iff (!NRST)
      !tick |=> $stable(free_cnt_r)) else $error("counter moved without tick");
   a_w1c_clear: assert property (@(posedge CLK) disable iff (!NRST)
      (wr_byte && wr_idx == IDX_STS && w_data_r[1] && !ev_ok[1]) |=> !sts_r[1])
      else $error("status not cleared");
endmodule : itc_top

// file: tb/itc_pins.sv
`timescale 1ns/1ns
// far-side model: two edge sources that change level just after a clock edge
module itc_pins (
   input  wire logic clk,
   output logic      pin_a,
   output logic      pin_b
);
   // both pins rest low, so the first change the block sees is a rising edge
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // the caller spaces calls by several cycles; shorter pulses may be lost in the synchroniser
   task automatic drive(input logic sel_b, input logic lvl);
      @(posedge clk);
      if (sel_b) begin
         pin_b <= lvl;
      end else begin
         pin_a <= lvl;
      end
   endtask : drive
endmodule : itc_pins

// file: tb/interval_timer_and_edge_capture_tb.sv
`timescale 1ns/1ns
module interval_timer_and_edge_capture_tb;
   import itc_pkg::*;
   logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, pit_irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, cap_irq;
   logic [1:0]  bresp, rresp;
   logic        pin_a, pin_b;
   int          miscompares, n_checks;

   itc_top i_itc_top (.CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .CAPTURE_INPUT_A(pin_a), .CAPTURE_INPUT_B(pin_b),
      .CAPTURE_IRQ(cap_irq), .INTERVAL_IRQ(pit_irq));
   itc_pins i_itc_pins (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

   // 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // handshakes are judged on pre-edge values, so ready and valid are sampled as the slave saw them
   task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      int i;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (i == 50) begin
         chk("write_timeout", 32'h1, 32'h0);
         test_done();
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (i == 50) begin
         chk("read_timeout", 32'h1, 32'h0);
         test_done();
      end
   endtask : axr

   // cycles until the next interval pulse; a pulse lasts one cycle so it is never counted twice
   task automatic wirq(input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(posedge clk);
         if (pit_irq === 1'b1) break;
      end
      if (n > lim) begin
         chk("irq_timeout", 32'h1, 32'h0);
         test_done();
      end
   endtask : wirq

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  s;
      for (int a = 8'h88; a <= 8'hB0; a += 4) begin
         axr(8'(a), d, s);
         chk("reset_value", d, 32'h0);
      end
      axw(8'hA8, 8'hFF, s);
      axr(8'hA8, d, s);
      chk("config_bits", d, 32'hF8);
      axw(8'hAC, 8'hFF, s);
      axr(8'hAC, d, s);
      chk("enable_bits", d, 32'h0F);
      // a small high nibble keeps the next reload short enough for the interval test
      axw(8'hA4, 8'hF1, s);
      axr(8'hA4, d, s);
      chk("reload_high_bits", d, 32'h01);
      axw(8'h00, 8'h01, s);
      chk("unmapped_write", 32'(s), 32'(RESP_SLVERR));
      axr(8'h04, d, s);
      chk("unmapped_read", 32'(s), 32'(RESP_SLVERR));
      axw(8'hA8, 8'h00, s);
      $display("done regs");
   endtask : t_regs

   // reload 0x105 expires every 0x106 ticks; right after expiry the count is 0x105
   task automatic t_pit;
      logic [31:0] d;
      logic [1:0]  s;
      int          n;
      axw(8'hA0, 8'h05, s);
      axw(8'hA4, 8'h01, s);
      wirq(7000, n);
      wirq(7000, n);
      wirq(7000, n);
      chk("pit_period", 32'(n), 32'(262 * TICK_CYC));
      axr(8'h98, d, s);
      chk("count_low", d, 32'h05);
      cyc(10 * TICK_CYC);
      axr(8'h9C, d, s);
      chk("count_high_latched", d, 32'h01);
      $display("done pit");
   endtask : t_pit

   // rise, fall 4 ticks later, rise 4 ticks later, fall one tick later
   task automatic t_hold(input logic hold);
      logic [31:0] r, f;
      logic [1:0]  s;
      axw(8'hA8, {hold, 7'h0}, s);
      axw(8'hAC, 8'h01, s);
      i_itc_pins.drive(1'b0, 1'b1);
      cyc(4 * TICK_CYC - 1);
      i_itc_pins.drive(1'b0, 1'b0);
      cyc(4 * TICK_CYC - 1);
      i_itc_pins.drive(1'b0, 1'b1);
      cyc(TICK_CYC - 1);
      i_itc_pins.drive(1'b0, 1'b0);
      cyc(10);
      axr(8'h88, r, s);
      axr(8'h90, f, s);
      chk("a_delta", 32'(8'(f - r)), hold ? 32'h4 : 32'h1);
      axr(8'hB0, r, s);
      chk("a_status", r, 32'h03);
      chk("a_irq_masked", 32'(cap_irq), 32'h1);
      axw(8'hB0, 8'h01, s);
      axr(8'hB0, r, s);
      chk("a_status_w1c", r, 32'h02);
      axw(8'hB0, 8'h02, s);
      $display("done hold %0d", hold);
   endtask : t_hold

   // pulse of 3 ticks scaled by 2^n shows as a delta of 3 for every prescale code
   task automatic t_pre;
      logic [31:0] r, f;
      logic [1:0]  s;
      axw(8'hAC, 8'h0F, s);
      for (int n = 0; n < 8; n++) begin
         axw(8'hA8, 8'(n << 4), s);
         i_itc_pins.drive(1'b1, 1'b1);
         cyc(3 * (TICK_CYC << n) - 1);
         i_itc_pins.drive(1'b1, 1'b0);
         cyc(10);
         axr(8'h8C, r, s);
         axr(8'h94, f, s);
         chk("b_delta", 32'(8'(f - r)), 32'h3);
         axr(8'hB0, r, s);
         chk("b_status", r, 32'h0C);
         chk("b_irq", 32'(cap_irq), 32'hC);
         axw(8'hB0, 8'h0C, s);
      end
      $display("done prescale");
   endtask : t_pre

   // 300 ticks overflow one byte, so only a true 16-bit pair gives the right delta
   task automatic t_wide;
      logic [31:0] ra, rb, fa, fb;
      logic [1:0]  s;
      axw(8'hA8, 8'h08, s);
      i_itc_pins.drive(1'b0, 1'b1);
      cyc(300 * TICK_CYC - 1);
      i_itc_pins.drive(1'b0, 1'b0);
      cyc(10);
      i_itc_pins.drive(1'b1, 1'b1);
      cyc(TICK_CYC);
      i_itc_pins.drive(1'b1, 1'b0);
      cyc(10);
      axr(8'h88, ra, s);
      axr(8'h8C, rb, s);
      axr(8'h90, fa, s);
      axr(8'h94, fb, s);
      chk("wide_delta", 32'(16'({fb[7:0], fa[7:0]} - {rb[7:0], ra[7:0]})), 32'd300);
      axr(8'hB0, ra, s);
      chk("wide_status", ra, 32'h03);
      $display("done wide");
   endtask : t_wide

   initial begin
      nrst    = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      awaddr  = 8'h00;
      araddr  = 8'h00;
      wdata   = 32'h0;
      wstrb   = 4'hF;
      miscompares = 0;
      n_checks    = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_pit();
      t_hold(1'b0);
      t_hold(1'b1);
      t_pre();
      t_wide();
      test_done();
   end
endmodule : interval_timer_and_edge_capture_tb
